// file: hdl/cdsa_top.sv
// Purpose: clock divider with sysref phase alignment, AHB-Lite registers
// Assumes: hclk is the input device clock; sysref pins synchronous to it
// Notes:   zero wait state slave, response always OKAY
`timescale 1ns/1ps

module cdsa_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        sysref_in,
   input  wire logic        sysref_late_half,
   output logic             div_tick,
   output logic             clk_invert,
   output logic      [3:0]  div_phase_offset,
   output logic      [1:0]  div_phase
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [2:0]  ratio_q;
   logic [3:0]  local_q;
   logic        auto_q;
   logic [1:0]  neg_q;
   logic [1:0]  posw_q;
   logic [1:0]  sren_q;
   logic [3:0]  status_q;
   logic [1:0]  cnt_q;
   logic [3:0]  off_q;
   logic        sysref_prev_q;
   logic        wr_q;
   logic [11:0] widx_q;
   logic [31:0] rdata_d;
   logic        addr_ok;
   logic [11:0] aidx;
   logic [1:0]  cyc_max;
   logic [1:0]  out_cnt;
   logic [3:0]  sum_off;

   cdsa_sysref_if sr ();

   cdsa_window u_window (
      .sr (sr)
   );

   // ------------------------------------------------------------
   // bus address phase
   // ------------------------------------------------------------
   assign aidx    = haddr[13:2];
   assign addr_ok = hsel && hready && htrans[1];

   // ------------------------------------------------------------
   // implemented bits of each writable register
   // ------------------------------------------------------------
   function automatic logic [7:0] cdsa_wr_mask(input logic [11:0] idx);
      case (idx)
         cdsa_pkg::IDX_RATIO: return 8'h07;
         cdsa_pkg::IDX_LOCAL: return 8'h0f;
         cdsa_pkg::IDX_CTRL:  return 8'h8f;
         cdsa_pkg::IDX_SREN:  return 8'h06;
         default:             return 8'h00;
      endcase
   endfunction : cdsa_wr_mask

   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (aidx)
         cdsa_pkg::IDX_RATIO:  rdata_d[2:0] = ratio_q;
         cdsa_pkg::IDX_LOCAL:  rdata_d[3:0] = local_q;
         cdsa_pkg::IDX_CTRL: begin
            rdata_d[cdsa_pkg::CTRL_AUTO_BIT]                     = auto_q;
            rdata_d[cdsa_pkg::CTRL_NEG_LSB +: 2]                 = neg_q;
            rdata_d[cdsa_pkg::CTRL_POS_LSB +: 2]                 = posw_q;
         end
         cdsa_pkg::IDX_STATUS: rdata_d[3:0] = status_q;
         cdsa_pkg::IDX_SREN:   rdata_d[cdsa_pkg::SREN_LSB +: 2] = sren_q;
         default:              rdata_d = 32'h0000_0000;
      endcase
      // write still landing: back-to-back read sees the new value
      if (wr_q && (widx_q == aidx) && (cdsa_wr_mask(aidx) != 8'h00)) begin
         rdata_d = {24'h00_0000, hwdata[7:0] & cdsa_wr_mask(aidx)};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         widx_q <= 12'h000;
      end else if (hready) begin
         wr_q   <= addr_ok && hwrite;
         widx_q <= aidx;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         hrdata <= rdata_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // register writes in data phase
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ratio_q <= cdsa_pkg::RST_RATIO;
         local_q <= cdsa_pkg::RST_LOCAL;
         auto_q  <= 1'b0;
         neg_q   <= cdsa_pkg::RST_WIN;
         posw_q  <= cdsa_pkg::RST_WIN;
         sren_q  <= cdsa_pkg::RST_SREN;
      end else if (wr_q) begin
         unique case (widx_q)
            cdsa_pkg::IDX_RATIO: ratio_q <= hwdata[2:0];
            cdsa_pkg::IDX_LOCAL: local_q <= hwdata[3:0];
            cdsa_pkg::IDX_CTRL: begin
               auto_q <= hwdata[cdsa_pkg::CTRL_AUTO_BIT];
               neg_q  <= hwdata[cdsa_pkg::CTRL_NEG_LSB +: 2];
               posw_q <= hwdata[cdsa_pkg::CTRL_POS_LSB +: 2];
            end
            cdsa_pkg::IDX_SREN:  sren_q  <= hwdata[cdsa_pkg::SREN_LSB +: 2];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // divider phase counter
   // ------------------------------------------------------------
   assign cyc_max = cdsa_pkg::cdsa_cyc_max(ratio_q);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 2'h0;
      end else if (cnt_q >= cyc_max) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
      end
   end

   // ------------------------------------------------------------
   // sysref capture
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sysref_prev_q <= 1'b0;
      end else begin
         sysref_prev_q <= sysref_in;
      end
   end

   always_comb begin
      sr.evt     = sysref_in && !sysref_prev_q && (sren_q != 2'h0);
      sr.pos     = {1'b0, cnt_q, sysref_late_half};
      sr.neg_win = neg_q;
      sr.pos_win = posw_q;
      sr.auto_en = auto_q;
      sr.cyc_max = cyc_max;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_q <= cdsa_pkg::RST_STATUS;
      end else if (sr.accept) begin
         status_q <= sr.pos;
      end
   end

   // ------------------------------------------------------------
   // applied offset and divided outputs
   // ------------------------------------------------------------
   assign sum_off = local_q + (auto_q ? status_q : 4'h0);
   assign out_cnt = (cnt_q - off_q[2:1]) & cyc_max;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         off_q <= 4'h0;
      end else begin
         off_q <= sum_off;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_tick         <= 1'b0;
         clk_invert       <= 1'b0;
         div_phase_offset <= 4'h0;
         div_phase        <= 2'h0;
      end else begin
         div_tick         <= (out_cnt == 2'h0);
         clk_invert       <= off_q[0];
         div_phase_offset <= off_q;
         div_phase        <= out_cnt;
      end
   end

endmodule : cdsa_top

// file: hdl/cdsa_pkg.sv
// Purpose: shared constants for the divider sysref phase align block
// Assumes: registers hold one byte each in the low lane of a 32-bit word
// Notes:   byte address of a register is four times its index
package cdsa_pkg;

   // ------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam logic [11:0] IDX_RATIO  = 12'h0108;
   localparam logic [11:0] IDX_LOCAL  = 12'h0109;
   localparam logic [11:0] IDX_CTRL   = 12'h010a;
   localparam logic [11:0] IDX_STATUS = 12'h010b;
   localparam logic [11:0] IDX_SREN   = 12'h0120;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_AUTO_BIT = 7;
   localparam int CTRL_NEG_LSB  = 2;
   localparam int CTRL_POS_LSB  = 0;
   localparam int SREN_LSB      = 1;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [2:0] RST_RATIO  = 3'h0;
   localparam logic [3:0] RST_LOCAL  = 4'h0;
   localparam logic [3:0] RST_STATUS = 4'h0;
   localparam logic [1:0] RST_WIN    = 2'h0;
   localparam logic [1:0] RST_SREN   = 2'h0;

   // ------------------------------------------------------------
   // ratio code to last full-cycle count of the divider
   // ------------------------------------------------------------
   function automatic logic [1:0] cdsa_cyc_max(input logic [2:0] ratio);
      if (ratio[1]) begin
         return 2'h3;
      end else if (ratio[0]) begin
         return 2'h1;
      end
      return 2'h0;
   endfunction : cdsa_cyc_max

endpackage : cdsa_pkg

// file: hdl/cdsa_sysref_if.sv
// Purpose: carries a sysref event and window setup to the window check
// Assumes: single clock domain
// Notes:   accept is combinational from the window check
`timescale 1ns/1ps
interface cdsa_sysref_if;
   logic       evt;
   logic [3:0] pos;
   logic [1:0] neg_win;
   logic [1:0] pos_win;
   logic       auto_en;
   logic [1:0] cyc_max;
   logic       accept;

   modport top (output evt, output pos, output neg_win, output pos_win,
                output auto_en, output cyc_max, input accept);
   modport win (input evt, input pos, input neg_win, input pos_win,
                input auto_en, input cyc_max, output accept);
endinterface : cdsa_sysref_if

// file: hdl/cdsa_window.sv
// Purpose: decides whether a sysref event lies outside both skew windows
// Assumes: pos is the event position in half input clocks in the divider cycle
// Notes:   pure combinational
`timescale 1ns/1ps
module cdsa_window (
   cdsa_sysref_if.win sr
);
   // ------------------------------------------------------------
   // window test
   // ------------------------------------------------------------
   logic [3:0] halves;
   logic       in_neg;
   logic       in_pos;

   always_comb begin
      halves = {1'b0, sr.cyc_max + 2'h1, 1'b0};
      if (sr.cyc_max == 2'h3) begin
         halves = 4'h8;
      end
      in_pos = (sr.pos != 4'h0) && (sr.pos <= {2'b00, sr.pos_win});
      in_neg = (sr.pos != 4'h0) && (sr.pos >= halves - {2'b00, sr.neg_win});
      // events are only accepted while auto adjust is on
      sr.accept = sr.evt && sr.auto_en && !in_neg && !in_pos;
   end
endmodule : cdsa_window

// file: bench/cdsa_checker.sv
// Purpose: port assertions for cdsa_top
// Assumes: one clock, async active-low reset
// Notes:   quiet_q counts cycles free of bus and sysref activity
`timescale 1ns/1ps
module cdsa_checker (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        sysref_in,
   input wire logic        div_tick,
   input wire logic        clk_invert,
   input wire logic [3:0]  div_phase_offset,
   input wire logic [1:0]  div_phase
);
   logic [3:0] quiet_q;
   wire logic  rd_go = hsel && htrans[1] && !hwrite && hreadyout;
   wire logic  rd_st = rd_go && (haddr[13:2] == cdsa_pkg::IDX_STATUS);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         quiet_q <= 4'h0;
      end else if (sysref_in || (hsel && htrans[1])) begin
         quiet_q <= 4'h0;
      end else if (quiet_q != 4'hf) begin
         quiet_q <= quiet_q + 4'h1;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("hresp not okay");
   property p_ready; $past(hresetn) |-> hreadyout; endproperty
   a_ready: assert property (p_ready) else $error("hreadyout low");
   property p_byte; $past(rd_go) |-> hrdata[31:8] == 24'h00_0000; endproperty
   a_byte: assert property (p_byte) else $error("upper read bits set");
   property p_stat; $past(rd_st) |-> hrdata[7:4] == 4'h0; endproperty
   a_stat: assert property (p_stat) else $error("status nibble set");
   property p_inv; clk_invert == div_phase_offset[0]; endproperty
   a_inv: assert property (p_inv) else $error("invert not offset lsb");
   property p_hold; quiet_q >= 4'h5 |-> $stable(div_phase_offset); endproperty
   a_hold: assert property (p_hold) else $error("offset moved");
   property p_tick; quiet_q >= 4'h8 && div_tick && !$past(div_tick) |-> ##1 !div_tick; endproperty
   a_tick: assert property (p_tick) else $error("tick too long");
   property p_step; quiet_q >= 4'h8 && !div_tick |-> div_phase != $past(div_phase); endproperty
   a_step: assert property (p_step) else $error("phase stuck");
   c_sysref: cover property ($rose(sysref_in));
   c_tick: cover property ($rose(div_tick));
   c_read: cover property (rd_st);
endmodule : cdsa_checker
bind cdsa_top cdsa_checker u_chk (.*);

// file: bench/cdsa_sysref_gen.sv
// Purpose: sysref source standing in for the clock generator
// Assumes: pulse is called just after a rising hclk edge
// Notes:   late flag wanders between pulses
`timescale 1ns/1ps
module cdsa_sysref_gen (
   input  wire logic hclk,
   output logic      sysref_in,
   output logic      sysref_late_half
);
   logic late_q = 1'b0;
   logic idle_q = 1'b0;
   initial sysref_in = 1'b0;
   always @(posedge hclk) idle_q <= !idle_q;
   assign sysref_late_half = sysref_in ? late_q : idle_q;
   task automatic pulse(input logic late);
      sysref_in <= 1'b1;
      late_q <= late;
      repeat (2) @(posedge hclk);
      sysref_in <= 1'b0;
      @(posedge hclk);
   endtask : pulse
endmodule : cdsa_sysref_gen

// file: bench/cdsa_top_tb.sv
// Purpose: self-checking bench for cdsa_top
// Assumes: zero wait state bus, sysref from cdsa_sysref_gen
// Notes:   rows use divide by one, so sysref position is the late flag
`timescale 1ns/1ps
module cdsa_top_tb;
   typedef struct {logic ae; logic [3:0] loc, st, off; logic late;} cdsa_row_type;
   cdsa_row_type rows [5] = '{'{1'b0, 4'h5, 4'h0, 4'h5, 1'b1}, '{1'b1, 4'h5, 4'h1, 4'h6, 1'b1},
      '{1'b1, 4'h2, 4'h0, 4'h2, 1'b0}, '{1'b1, 4'hf, 4'h1, 4'h0, 1'b1},
      '{1'b1, 4'h3, 4'h0, 4'h3, 1'b0}};
   logic [11:0] ix [5] = '{cdsa_pkg::IDX_RATIO, cdsa_pkg::IDX_LOCAL, cdsa_pkg::IDX_CTRL,
                          cdsa_pkg::IDX_STATUS, 12'h0100};
   logic [7:0]  rt [3] = '{8'h00, 8'h01, 8'h03};
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, rv;
   logic [3:0]  div_phase_offset;
   logic [1:0]  div_phase;
   logic        hreadyout, hresp, sysref_in, sysref_late_half, div_tick, clk_invert;
   wire logic   hready = hreadyout;
   int          num_errors = 0, n_tests = 0, cyc = 0, nt;
   cdsa_top uut (.*);
   cdsa_sysref_gen gen (.*);
   always #2 hclk = ~hclk;
   task automatic summarize();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic ck(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : ck
   task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {18'h0_0000, a, 2'h0};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, wd};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rv = hrdata;
   endtask : xf
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (ix[j]) begin
         xf(1'b0, ix[j], 8'h00);
         ck("reset reg", 8'h00, rv[7:0]);
      end
      $display("test reset done");
      xf(1'b1, cdsa_pkg::IDX_SREN, 8'h06);
      foreach (rows[i]) begin
         xf(1'b1, cdsa_pkg::IDX_LOCAL, 8'(rows[i].loc));
         xf(1'b1, cdsa_pkg::IDX_CTRL, {rows[i].ae, 7'h00});
         gen.pulse(rows[i].late);
         repeat (4) @(posedge hclk);
         xf(1'b0, cdsa_pkg::IDX_STATUS, 8'h00);
         ck("status", 8'(rows[i].st), rv[7:0]);
         ck("offset", 8'(rows[i].off), 8'(div_phase_offset));
         ck("invert", 8'(rows[i].off[0]), 8'(clk_invert));
      end
      $display("test rows done");
      xf(1'b1, cdsa_pkg::IDX_STATUS, 8'h0f);
      xf(1'b0, cdsa_pkg::IDX_STATUS, 8'h00);
      ck("status ro", 8'h00, rv[7:0]);
      xf(1'b1, cdsa_pkg::IDX_CTRL, 8'hf0);
      xf(1'b0, cdsa_pkg::IDX_CTRL, 8'h00);
      ck("ctrl rsvd", 8'h80, rv[7:0]);
      $display("test access done");
      foreach (rt[j]) begin
         xf(1'b1, cdsa_pkg::IDX_RATIO, rt[j]);
         repeat (4) @(posedge hclk);
         nt = 0;
         repeat (8) begin
            @(posedge hclk);
            if (div_tick === 1'b1) nt++;
         end
         ck("ticks", 8'(8 >> j), 8'(nt));
      end
      $display("test divide done");
      xf(1'b1, cdsa_pkg::IDX_SREN, 8'h00);
      xf(1'b1, cdsa_pkg::IDX_CTRL, 8'h85);
      xf(1'b1, cdsa_pkg::IDX_SREN, 8'h06);
      for (int k = 0; k < 8; k++) begin
         repeat (k % 4) @(posedge hclk);
         gen.pulse(1'b1);
         xf(1'b0, cdsa_pkg::IDX_STATUS, 8'h00);
         ck("win st", 8'h01, 8'(rv == 0 || rv == 3 || rv == 5));
         ck("win off", 8'(4'h3 + rv[3:0]), 8'(div_phase_offset));
      end
      ck("win hit", 8'h01, 8'(rv == 3 || rv == 5));
      $display("test window done");
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= 1'b1;
      haddr <= {18'h0_0000, cdsa_pkg::IDX_LOCAL, 2'h0};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hwrite <= 1'b0;
      hwdata <= 32'h0000_0009;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      ck("pipe read", 8'h09, hrdata[7:0]);
      $display("test pipeline done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xf(1'b0, cdsa_pkg::IDX_STATUS, 8'h00);
      ck("reset status", 8'h00, rv[7:0]);
      ck("reset offset", 8'h00, 8'(div_phase_offset));
      $display("test second reset done");
      summarize();
   end
endmodule : cdsa_top_tb
